//--- hw/lock_timer.v
// Settling timer that raises the PLL lock indication
`timescale 1ns/1ns

module lock_timer #(
    parameter CYCLES = 10000
) (
    input wire clk,
    input wire sys_rst,
    input wire restart,
    output reg locked
);

    reg [31:0] count;

    always @(posedge clk) begin
        if (sys_rst || restart) begin
            count <= 32'h0;
            locked <= 1'b0;
        end else if (count >= CYCLES - 1) begin
            locked <= 1'b1;
        end else begin
            count <= count + 32'h1;
        end
    end

endmodule

//--- hw/prbs7_lane.v
// PRBS 2^7-1 generator and self-synchronising checker for one lane
`timescale 1ns/1ns
`include "xcvr_mode_defs.vh"

module prbs7_lane #(
    parameter WIDTH = 10
) (
    input wire clk,
    input wire sys_rst,
    input wire enable,
    input wire [WIDTH-1:0] rx_word,
    output reg [WIDTH-1:0] tx_word,
    output reg mismatch
);

    // ----------------------------------------
    // Next polynomial bit, x^7 + x^6 + 1
    // ----------------------------------------
    function next_bit;
        input [6:0] s;
        begin
            next_bit = s[6] ^ s[5];
        end
    endfunction

    reg [6:0] gen_state;
    reg [6:0] chk_state;
    reg [6:0] g;
    reg [6:0] c;
    reg [WIDTH-1:0] word;
    reg err;
    integer i;

    always @* begin
        g = gen_state;
        c = chk_state;
        word = {WIDTH{1'b0}};
        err = 1'b0;
        for (i = WIDTH - 1; i >= 0; i = i - 1) begin
            word[i] = next_bit(g);
            g = {g[5:0], next_bit(g)};
            // Checker seeds from received bits, so it locks after 7 good bits
            if (rx_word[i] != next_bit(c)) begin
                err = 1'b1;
            end
            c = {c[5:0], rx_word[i]};
        end
    end

    always @(posedge clk) begin
        if (sys_rst || !enable) begin
            gen_state <= `PRBS_SEED;
            chk_state <= `PRBS_SEED;
            tx_word <= {WIDTH{1'b0}};
            mismatch <= 1'b0;
        end else begin
            gen_state <= g;
            chk_state <= c;
            tx_word <= word;
            mismatch <= err;
        end
    end

endmodule

//--- hw/transceiver_mode_control.v
// Mode, configuration and test control for an eight-lane serial transceiver
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "xcvr_mode_defs.vh"

module transceiver_mode_control #(
    parameter LANES = 8,
    parameter LOCK_CYCLES = `LOCK_CYCLES
) (
    input wire clk,
    input wire sys_rst,
    // Strap and control pins
    input wire chip_reset_pin,
    input wire [4:0] phys_address_straps,
    input wire code_pin,
    input wire error_fill_enable_pin,
    input wire serial_loopback_pin,
    input wire [1:0] interface_select_pins,
    input wire device_enable_pin,
    input wire transfer_clock_select_pin,
    input wire busy_pass_enable_pin,
    input wire gige_idle_handling_pin,
    input wire prbs_test_enable_pin,
    input wire power_down_pin,
    input wire jtag_shifting,
    // Register port, fed by the management frame engine on MDC
    input wire [4:0] reg_phy_addr,
    input wire [4:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [15:0] reg_rdata,
    // Transmit characters ahead of the encoder
    input wire [8*LANES-1:0] tx_char_in,
    input wire [LANES-1:0] tx_k_in,
    output reg [8*LANES-1:0] tx_char_out,
    output reg [LANES-1:0] tx_k_out,
    // Encoded words around the serial path
    input wire [10*LANES-1:0] encoder_word,
    input wire [10*LANES-1:0] serial_rx_word,
    output reg [10*LANES-1:0] serial_tx_word,
    output reg serial_tx_oe,
    output reg [10*LANES-1:0] decoder_in_word,
    // Decoder results
    input wire [10*LANES-1:0] rx_data_in,
    input wire [LANES-1:0] rx_code_error,
    input wire [8*LANES-1:0] rx_char,
    input wire [LANES-1:0] rx_k,
    output reg [10*LANES-1:0] rx_data_out,
    output reg [LANES-1:0] idle_deletable,
    // Mode outputs
    output reg coding_enable,
    output reg mux_channel_mode,
    output reg nibble_mode,
    output reg independent_clocks,
    output reg busy_pass_enable,
    output reg recenter_buffers,
    output reg outputs_oe,
    output reg tdo_oe,
    output reg pll_lock
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function is_k28_5;
        input [7:0] ch;
        input k;
        begin
            is_k28_5 = k && (ch == `CHAR_K28_5);
        end
    endfunction

    // Pin and register bit act alike; either one switches the feature on, error fill only while coding is on
    function either_set;
        input pin;
        input ctrl;
        begin
            either_set = pin | ctrl;
        end
    endfunction

    // ----------------------------------------
    // Reset pin edge and address latch
    // ----------------------------------------
    reg reset_pin_q;
    reg [4:0] phys_addr;
    wire reset_rise = chip_reset_pin && !reset_pin_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            reset_pin_q <= 1'b0;
            phys_addr <= 5'h00;
            recenter_buffers <= 1'b0;
        end else begin
            reset_pin_q <= chip_reset_pin;
            // Strap level taken by a clocked process, never by the reset
            if (reset_rise) begin
                phys_addr <= phys_address_straps;
            end
            recenter_buffers <= chip_reset_pin;
        end
    end

    // ----------------------------------------
    // Management registers
    // ----------------------------------------
    reg coding_enable_bit;
    reg error_fill_enable_bit;
    reg transfer_clock_select_bit;
    reg gige_idle_handling_bit;
    reg [LANES-1:0] prbs_fail;
    wire [LANES-1:0] lane_mismatch;
    wire locked;

    wire addressed = (reg_phy_addr == phys_addr);
    wire wr_ok = reg_write && addressed;
    wire rd_ok = reg_read && addressed;

    always @(posedge clk) begin
        if (sys_rst) begin
            coding_enable_bit <= `CTRL_RESET_BIT;
            error_fill_enable_bit <= `CTRL_RESET_BIT;
            transfer_clock_select_bit <= `CTRL_RESET_BIT;
            gige_idle_handling_bit <= `CTRL_RESET_BIT;
        end else if (wr_ok) begin
            if (reg_addr == `REG_CTRL_A) begin
                coding_enable_bit <= reg_wdata[`CTRL_A_CODING_BIT];
                error_fill_enable_bit <= reg_wdata[`CTRL_A_FILL_BIT];
                transfer_clock_select_bit <= reg_wdata[`CTRL_A_CLKSEL_BIT];
            end
            if (reg_addr == `REG_CTRL_B) begin
                gige_idle_handling_bit <= reg_wdata[`CTRL_B_GIGE_BIT];
            end
        end
    end

    // Sticky PRBS failures; a new mismatch wins over a write-one clear
    wire [LANES-1:0] fail_clear = (wr_ok && reg_addr == `REG_STATUS) ? reg_wdata[LANES-1:0] : {LANES{1'b0}};

    always @(posedge clk) begin
        if (sys_rst || chip_reset_pin) begin
            prbs_fail <= {LANES{1'b0}};
        end else begin
            prbs_fail <= (prbs_fail & ~fail_clear) | lane_mismatch;
        end
    end

    // ----------------------------------------
    // Effective settings
    // ----------------------------------------
    wire eff_coding = either_set(code_pin, coding_enable_bit);
    wire eff_fill = either_set(error_fill_enable_pin, error_fill_enable_bit) & eff_coding;
    wire eff_clksel = either_set(transfer_clock_select_pin, transfer_clock_select_bit);
    wire eff_gige = either_set(gige_idle_handling_pin, gige_idle_handling_bit);

    // Read data stands one cycle; zero otherwise keeps the port quiet

    always @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (rd_ok) begin
            case (reg_addr)
                `REG_CTRL_A: begin
                    reg_rdata <= {transfer_clock_select_bit, error_fill_enable_bit, 6'h00,
                        coding_enable_bit, 7'h00};
                end
                `REG_CTRL_B: begin
                    reg_rdata <= {gige_idle_handling_bit, 15'h0000};
                end
                `REG_STATUS: begin
                    reg_rdata <= {2'b00, phys_addr, locked, prbs_fail};
                end
                `REG_EFFECTIVE: begin
                    reg_rdata <= {8'h00, prbs_test_enable_pin, eff_gige, busy_pass_enable_pin, eff_clksel,
                        serial_loopback_pin, eff_fill, eff_coding, locked};
                end
                default: begin
                    reg_rdata <= 16'h0000;
                end
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ----------------------------------------
    // Mode outputs
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            coding_enable <= 1'b0;
            mux_channel_mode <= 1'b0;
            nibble_mode <= 1'b0;
            independent_clocks <= 1'b0;
            busy_pass_enable <= 1'b0;
            outputs_oe <= 1'b0;
            tdo_oe <= 1'b0;
            serial_tx_oe <= 1'b0;
            pll_lock <= 1'b0;
        end else begin
            coding_enable <= eff_coding;
            // Reserved codes leave both modes off
            mux_channel_mode <= (interface_select_pins == `IF_MUX_CHANNEL);
            nibble_mode <= (interface_select_pins == `IF_NIBBLE);
            // High: per-lane clocks; low: shared transmit and receive clocks
            independent_clocks <= eff_clksel;
            busy_pass_enable <= busy_pass_enable_pin;
            outputs_oe <= device_enable_pin;
            tdo_oe <= device_enable_pin && jtag_shifting;
            serial_tx_oe <= device_enable_pin && !serial_loopback_pin;
            pll_lock <= locked;
        end
    end

    // ----------------------------------------
    // Lock timer and PRBS lanes
    // ----------------------------------------
    // Power-down restarts the count; sys_rst covers power-up
    lock_timer #(
        .CYCLES(LOCK_CYCLES)
    ) u_lock (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(power_down_pin),
        .locked(locked)
    );

    wire [10*LANES-1:0] prbs_word;

    // Each lane checks what reaches its decoder, so loopback tests the lane
    genvar gl;
    generate
        for (gl = 0; gl < LANES; gl = gl + 1) begin : g_lane
            prbs7_lane #(
                .WIDTH(10)
            ) u_prbs (
                .clk(clk),
                .sys_rst(sys_rst),
                .enable(prbs_test_enable_pin),
                .rx_word(decoder_in_word[10*gl +: 10]),
                .tx_word(prbs_word[10*gl +: 10]),
                .mismatch(lane_mismatch[gl])
            );
        end
    endgenerate

    // ----------------------------------------
    // Data paths
    // ----------------------------------------
    reg [LANES-1:0] tx_prev_k285;
    reg [LANES-1:0] rx_prev_k285;
    reg [10*LANES-1:0] next_serial_tx;
    reg [10*LANES-1:0] next_decoder_in;
    reg [10*LANES-1:0] next_rx_out;
    reg [8*LANES-1:0] next_tx_char;
    reg [LANES-1:0] next_idle;
    reg [7:0] ch;
    integer n;
    integer m;

    always @* begin
        next_serial_tx = prbs_test_enable_pin ? prbs_word : encoder_word;
        // Loopback replaces the serial receive words entirely
        next_decoder_in = serial_loopback_pin ? next_serial_tx : serial_rx_word;
        next_rx_out = rx_data_in;
        next_tx_char = tx_char_in;
        next_idle = {LANES{1'b0}};
        ch = 8'h00;
        for (n = 0; n < LANES; n = n + 1) begin
            if (eff_fill && rx_code_error[n]) begin
                next_rx_out[10*n +: 10] = `FILL_WORD;
            end
            if (eff_gige && tx_prev_k285[n] && !tx_k_in[n] && tx_char_in[8*n +: 8] == `CHAR_D16_2) begin
                next_tx_char[8*n +: 8] = `CHAR_D5_6;
            end
            ch = rx_char[8*n +: 8];
            if (rx_prev_k285[n] && !rx_k[n] && !rx_code_error[n]) begin
                if (ch == `CHAR_D10_1) begin
                    next_idle[n] = !busy_pass_enable_pin;
                end else begin
                    next_idle[n] = eff_gige;
                end
            end
        end
    end

    // Remember a K28.5 per lane so the next character can be judged
    always @(posedge clk) begin
        if (sys_rst) begin
            tx_prev_k285 <= {LANES{1'b0}};
            rx_prev_k285 <= {LANES{1'b0}};
        end else begin
            for (m = 0; m < LANES; m = m + 1) begin
                tx_prev_k285[m] <= is_k28_5(tx_char_in[8*m +: 8], tx_k_in[m]);
                rx_prev_k285[m] <= is_k28_5(rx_char[8*m +: 8], rx_k[m]);
            end
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            serial_tx_word <= {10*LANES{1'b0}};
            decoder_in_word <= {10*LANES{1'b0}};
            rx_data_out <= {10*LANES{1'b0}};
            tx_char_out <= {8*LANES{1'b0}};
            tx_k_out <= {LANES{1'b0}};
            idle_deletable <= {LANES{1'b0}};
        end else begin
            serial_tx_word <= next_serial_tx;
            decoder_in_word <= next_decoder_in;
            rx_data_out <= next_rx_out;
            tx_char_out <= next_tx_char;
            tx_k_out <= tx_k_in;
            idle_deletable <= next_idle;
        end
    end

endmodule

//--- pkg/xcvr_mode_defs.vh
// Constants for the transceiver mode control block
`ifndef XCVR_MODE_DEFS_VH
`define XCVR_MODE_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL_A      5'h11
`define REG_CTRL_B      5'h18
`define REG_STATUS      5'h19
`define REG_EFFECTIVE   5'h1a

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_A_CODING_BIT      7
`define CTRL_A_FILL_BIT        14
`define CTRL_A_CLKSEL_BIT      15
`define CTRL_B_GIGE_BIT        15
`define STATUS_LOCK_BIT        8
`define STATUS_ADDR_LSB        9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RESET_BIT         1'b0
`define PRBS_SEED              7'h7f

// ----------------------------------------
// Characters
// ----------------------------------------
`define CHAR_K28_5             8'hbc
`define CHAR_D10_1             8'h2a
`define CHAR_D16_2             8'h50
`define CHAR_D5_6              8'hc5
`define FILL_WORD              10'h3ff

// ----------------------------------------
// Parallel interface select
// ----------------------------------------
`define IF_MUX_CHANNEL         2'b00
`define IF_NIBBLE              2'b10

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS          10
`define LOCK_TIME_NS           100000
`define LOCK_CYCLES            (`LOCK_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- tb/far_end_model.sv
// Far-end link partner: echoes the serial stream back
`timescale 1ns/1ns

module far_end_model (
    input logic clk,
    input logic [79:0] serial_tx_word,
    input logic serial_tx_oe,
    input logic corrupt,
    output logic [79:0] serial_rx_word
);
    initial serial_rx_word = '0;
    // Released line: invert so a stale word never passes as live data
    always @(posedge clk) begin
        if (serial_tx_oe) begin
            serial_rx_word <= serial_tx_word ^ {79'h0, corrupt};
        end else begin
            serial_rx_word <= ~serial_rx_word;
        end
    end
endmodule

//--- tb/transceiver_mode_control_bench.sv
// Self-checking bench for the transceiver mode control block
`timescale 1ns/1ns
`include "xcvr_mode_defs.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; $display("Error t=%0t got %h exp %h", $time, a, e); end end

module transceiver_mode_control_bench;
    localparam LK = 20;
    logic clk, sys_rst, chip_reset_pin, code_pin, error_fill_enable_pin, serial_loopback_pin, device_enable_pin;
    logic transfer_clock_select_pin, busy_pass_enable_pin, gige_idle_handling_pin, prbs_test_enable_pin;
    logic power_down_pin, jtag_shifting, reg_write, reg_read, corrupt, f;
    logic serial_tx_oe, coding_enable, mux_channel_mode, nibble_mode, independent_clocks, busy_pass_enable;
    logic recenter_buffers, outputs_oe, tdo_oe, pll_lock;
    logic [4:0] phys_address_straps, reg_phy_addr, reg_addr;
    logic [1:0] interface_select_pins;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [63:0] tx_char_in, tx_char_out, rx_char;
    logic [7:0] tx_k_in, tx_k_out, rx_code_error, rx_k, idle_deletable, c;
    logic [79:0] encoder_word, serial_rx_word, serial_tx_word, decoder_in_word, rx_data_in, rx_data_out;
    logic [95:0] w;
    logic [31:0] r;
    logic [31:0] seed = 32'h9e8c;
    int err_count, n_tests, i, b, g, k, ctrl_a, ctrl_b;
    int cycles = 0;

    transceiver_mode_control #(.LOCK_CYCLES(LK)) dut_u (
        .clk, .sys_rst, .chip_reset_pin, .phys_address_straps, .code_pin, .error_fill_enable_pin,
        .serial_loopback_pin, .interface_select_pins, .device_enable_pin, .transfer_clock_select_pin,
        .busy_pass_enable_pin, .gige_idle_handling_pin, .prbs_test_enable_pin, .power_down_pin,
        .jtag_shifting, .reg_phy_addr, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .tx_char_in, .tx_k_in, .tx_char_out, .tx_k_out, .encoder_word, .serial_rx_word,
        .serial_tx_word, .serial_tx_oe, .decoder_in_word, .rx_data_in, .rx_code_error, .rx_char,
        .rx_k, .rx_data_out, .idle_deletable, .coding_enable, .mux_channel_mode, .nibble_mode,
        .independent_clocks, .busy_pass_enable, .recenter_buffers, .outputs_oe, .tdo_oe, .pll_lock
    );
    far_end_model far_u (.clk, .serial_tx_word, .serial_tx_oe, .corrupt, .serial_rx_word);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            summarize();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] eff();
        return {8'h0, prbs_test_enable_pin, gige_idle_handling_pin | ctrl_b[15], busy_pass_enable_pin,
                transfer_clock_select_pin | ctrl_a[15], serial_loopback_pin,
                (error_fill_enable_pin | ctrl_a[14]) & (code_pin | ctrl_a[7]), code_pin | ctrl_a[7], 1'b1};
    endfunction

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {sys_rst, device_enable_pin} = 2'b11;
        {chip_reset_pin, code_pin, error_fill_enable_pin, serial_loopback_pin, transfer_clock_select_pin,
         busy_pass_enable_pin, gige_idle_handling_pin, prbs_test_enable_pin, power_down_pin, jtag_shifting,
         reg_write, reg_read, corrupt} = '0;
        phys_address_straps = 5'h0b;
        reg_phy_addr = 5'h0b;
        {reg_addr, interface_select_pins, reg_wdata, tx_char_in, tx_k_in, rx_code_error, rx_char, rx_k} = '0;
        {encoder_word, rx_data_in} = '0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chip_reset_pin <= 1'b1;
        @(posedge clk);
        chip_reset_pin <= 1'b0;
        phys_address_straps <= 5'h1f;
        repeat (LK + 6) @(posedge clk);
        rd(`REG_CTRL_A, d);
        `CHK(d, 16'h0)
        rd(`REG_CTRL_B, d);
        `CHK(d, 16'h0)
        rd(`REG_STATUS, d);
        `CHK(d, 16'h1700)
        @(posedge clk);
        reg_phy_addr <= 5'h04;
        wr(`REG_CTRL_A, 16'hffff);
        reg_phy_addr <= 5'h0b;
        rd(`REG_CTRL_A, d);
        `CHK(d, 16'h0)
        rd(5'h05, d);
        `CHK(d, 16'h0)
        $display("test address and reset done");

        repeat (30) begin
            r = rnd();
            ctrl_a = r[31:16] & 16'hc080;
            ctrl_b = {r[13], 15'h0};
            wr(`REG_CTRL_A, ctrl_a[15:0]);
            wr(`REG_CTRL_B, ctrl_b[15:0]);
            w = {rnd(), rnd(), rnd()};
            @(posedge clk);
            {code_pin, error_fill_enable_pin, transfer_clock_select_pin, gige_idle_handling_pin,
             serial_loopback_pin, busy_pass_enable_pin, jtag_shifting, device_enable_pin} <= r[7:0];
            interface_select_pins <= r[9:8];
            rx_data_in <= w[79:0];
            rx_code_error <= w[87:80];
            encoder_word <= w[95:16];
            rd(`REG_EFFECTIVE, d);
            `CHK(d, eff())
            f = (code_pin | ctrl_a[7]) & (error_fill_enable_pin | ctrl_a[14]);
            for (i = 0; i < 8; i++) begin
                `CHK(rx_data_out[10*i+:10], (f && rx_code_error[i]) ? 10'h3ff : rx_data_in[10*i+:10])
            end
            `CHK(independent_clocks, transfer_clock_select_pin | ctrl_a[15])
            `CHK(coding_enable, code_pin | ctrl_a[7])
        end
        $display("test mode combinations done");

        ctrl_b = 0;
        wr(`REG_CTRL_B, 16'h0);
        for (b = 0; b < 2; b++) begin
            for (g = 0; g < 2; g++) begin
                for (k = 0; k < 2; k++) begin
                    c = k ? `CHAR_D16_2 : `CHAR_D10_1;
                    @(posedge clk);
                    busy_pass_enable_pin <= b[0];
                    gige_idle_handling_pin <= g[0];
                    rx_code_error <= 8'h00;
                    rx_char <= {8{`CHAR_K28_5}};
                    rx_k <= 8'hff;
                    tx_char_in <= {8{`CHAR_K28_5}};
                    tx_k_in <= 8'hff;
                    @(posedge clk);
                    rx_char <= {8{c}};
                    rx_k <= 8'h00;
                    tx_char_in <= {8{c}};
                    tx_k_in <= 8'h00;
                    @(posedge clk);
                    #1;
                    `CHK(idle_deletable, {8{k ? g[0] : !b[0]}})
                    `CHK(tx_char_out[7:0], (g && k) ? `CHAR_D5_6 : c)
                    `CHK(tx_k_out, 8'h00)
                end
            end
        end
        $display("test idle handling done");

        @(posedge clk);
        power_down_pin <= 1'b1;
        repeat (3) @(posedge clk);
        power_down_pin <= 1'b0;
        repeat (LK - 2) @(posedge clk);
        #1;
        `CHK(pll_lock, 1'b0)
        repeat (6) @(posedge clk);
        #1;
        `CHK(pll_lock, 1'b1)
        $display("test lock done");

        @(posedge clk);
        {serial_loopback_pin, prbs_test_enable_pin, device_enable_pin} <= 3'b111;
        repeat (20) @(posedge clk);
        wr(`REG_STATUS, 16'h00ff);
        repeat (20) @(posedge clk);
        rd(`REG_STATUS, d);
        `CHK(d, 16'h1700)
        `CHK(serial_tx_word[9:0] != 10'h000, 1'b1)
        `CHK(serial_tx_word[2:0], serial_tx_word[9:7] ^ serial_tx_word[8:6])
        @(posedge clk);
        corrupt <= 1'b1;
        serial_loopback_pin <= 1'b0;
        repeat (20) @(posedge clk);
        wr(`REG_STATUS, 16'h00ff);
        repeat (20) @(posedge clk);
        rd(`REG_STATUS, d);
        `CHK(d, 16'h1701)
        $display("test prbs done");
        summarize();
    end
endmodule

//--- tb/xcvr_mode_monitor.sv
// Checker bound to the transceiver mode control block
`timescale 1ns/1ns

module xcvr_mode_monitor #(
    parameter LANES = 8
) (
    input logic clk,
    input logic sys_rst,
    input logic chip_reset_pin,
    input logic code_pin,
    input logic serial_loopback_pin,
    input logic [1:0] interface_select_pins,
    input logic device_enable_pin,
    input logic transfer_clock_select_pin,
    input logic busy_pass_enable_pin,
    input logic power_down_pin,
    input logic jtag_shifting,
    input logic reg_read,
    input logic [15:0] reg_rdata,
    input logic [10*LANES-1:0] serial_rx_word,
    input logic [10*LANES-1:0] serial_tx_word,
    input logic serial_tx_oe,
    input logic [10*LANES-1:0] decoder_in_word,
    input logic coding_enable,
    input logic mux_channel_mode,
    input logic nibble_mode,
    input logic independent_clocks,
    input logic busy_pass_enable,
    input logic recenter_buffers,
    input logic outputs_oe,
    input logic tdo_oe,
    input logic pll_lock
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Lock must stay low through the settling window, then come within a bound
    sequence s_settling;
        !pll_lock [*8];
    endsequence
    property p_lock_settle;
        $fell(power_down_pin) |-> s_settling ##[8:40] pll_lock;
    endproperty
    a_lock_settle: assert property (p_lock_settle) else $error("lock timing wrong");
    property p_loop;
        serial_loopback_pin |=> !serial_tx_oe && decoder_in_word == serial_tx_word;
    endproperty
    a_loop: assert property (p_loop) else $error("loopback path wrong");
    property p_normal;
        !serial_loopback_pin |=> decoder_in_word == $past(serial_rx_word);
    endproperty
    a_normal: assert property (p_normal) else $error("receive path wrong");
    property p_enable;
        1'b1 |=> outputs_oe == $past(device_enable_pin);
    endproperty
    a_enable: assert property (p_enable) else $error("output enable wrong");
    property p_tdo;
        !jtag_shifting || !device_enable_pin |=> !tdo_oe;
    endproperty
    a_tdo: assert property (p_tdo) else $error("tdo driven idle");
    property p_coding;
        code_pin |=> coding_enable;
    endproperty
    a_coding: assert property (p_coding) else $error("coding off");
    property p_nibble;
        interface_select_pins == 2'b10 |=> nibble_mode && !mux_channel_mode;
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble mode wrong");
    property p_mux;
        interface_select_pins != 2'b10 |=> !nibble_mode && mux_channel_mode == $past(interface_select_pins == 2'b00);
    endproperty
    a_mux: assert property (p_mux) else $error("mux mode wrong");
    property p_recenter;
        chip_reset_pin |=> recenter_buffers;
    endproperty
    a_recenter: assert property (p_recenter) else $error("no recenter");
    property p_clksel;
        transfer_clock_select_pin |=> independent_clocks;
    endproperty
    a_clksel: assert property (p_clksel) else $error("clock select wrong");
    property p_busy;
        busy_pass_enable_pin != busy_pass_enable |=> busy_pass_enable == $past(busy_pass_enable_pin);
    endproperty
    a_busy: assert property (p_busy) else $error("busy pass wrong");
    property p_rdata;
        !reg_read |=> reg_rdata == 16'h0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("stale read data");
endmodule

bind transceiver_mode_control xcvr_mode_monitor #(.LANES(LANES)) mon_u (
    .clk, .sys_rst, .chip_reset_pin, .code_pin, .serial_loopback_pin, .interface_select_pins,
    .device_enable_pin, .transfer_clock_select_pin, .busy_pass_enable_pin, .power_down_pin,
    .jtag_shifting, .reg_read, .reg_rdata, .serial_rx_word, .serial_tx_word, .serial_tx_oe,
    .decoder_in_word, .coding_enable, .mux_channel_mode, .nibble_mode, .independent_clocks,
    .busy_pass_enable, .recenter_buffers, .outputs_oe, .tdo_oe, .pll_lock
);
